// ---- rtl/flash_ctrl_pkg.sv ----
package flash_ctrl_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] KEY_OFS        = 8'h04;
	localparam logic [7:0] PAGE_OFS       = 8'h08;
	localparam logic [7:0] OFFSET_OFS     = 8'h0c;
	localparam logic [7:0] STATUS_OFS     = 8'h10;
	localparam logic [7:0] LATCH_IDX_OFS  = 8'h14;
	localparam logic [7:0] LATCH_DATA_OFS = 8'h18;

	// ----------------------------------------
	// Control fields and codes
	// ----------------------------------------
	localparam int          START_BIT      = 15;
	localparam int          WRITE_PERMIT_BIT_BIT       = 14;
	localparam int          ERASE_BIT      = 6;
	localparam logic [3:0]  OP_ROW_PROG    = 4'h1;
	localparam logic [3:0]  OP_BLOCK_ERASE = 4'h2;
	localparam logic [3:0]  OP_BULK_ERASE  = 4'h3;
	localparam logic [7:0]  KEY_FIRST      = 8'h55;
	localparam logic [7:0]  KEY_SECOND     = 8'haa;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [7:0]  PAGE_RESET     = 8'h00;
	localparam logic [15:0] OFFSET_RESET   = 16'h0000;

	// ----------------------------------------
	// Array geometry and timing
	// ----------------------------------------
	localparam int ROW_WORDS     = 64;
	localparam int BLOCK_ROWS    = 8;
	localparam int BLOCK_WORDS   = ROW_WORDS * BLOCK_ROWS;
	localparam int CLK_MHZ       = 250;
	localparam int ERASE_TIME_US = 20000;
	localparam int PROG_TIME_US  = 2000;
	localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
	localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;

	typedef struct packed {
		logic        write_permit_bit;
		logic        erase;
		logic [3:0]  op;
	} flash_cfg_t;

	typedef struct packed {
		logic        wr_en;
		logic        erase;
		logic        bulk;
		logic [23:0] addr;
		logic [23:0] data;
	} flash_cmd_t;

endpackage : flash_ctrl_pkg

// ---- rtl/flash_program_erase_control.sv ----
// Behaviour
// - Code 0010 with erase set selects block erase.
// - Erase at bit 6, write-enable at bit 14.
// - Code 0001, erase clear, enable set: row program.
// - Start refused without key sequence just before.
// - Start erases, stalls processor, start self-clears.
// - Start programs row and stalls until done.
// - Start bit clears when row write completes.
// - Erase unit is eight rows, 512 instructions.
// - Row write takes 64 words from latches.
// - Only one row programmed per operation.
// - Bulk erase only in serial programming mode.
// - Start bit launches operation, reads 0 when idle.
// - Write-enable clear blocks all program and erase.
//
// Design decisions made here: the address map and register access over Wishbone.
module flash_program_erase_control
	import flash_ctrl_pkg::*;
#(
	parameter int unsigned ERASE_CYC = ERASE_CYCLES,
	parameter int unsigned PROG_CYC  = PROG_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial_prog_mode,
	output logic             cpu_stall,
	output flash_cmd_t       flash_cmd
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_PROG_LOAD,
		ST_WAIT
	} seq_state_t;

	typedef enum logic [1:0] {
		KEY_NONE,
		KEY_HALF,
		KEY_OPEN
	} key_state_t;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	seq_state_t  state_reg;
	key_state_t  key_reg;
	flash_cfg_t  cfg_reg;
	flash_cfg_t  cfg_next;
	flash_cmd_t  cmd_reg;
	logic        start_reg;
	logic        stall_reg;
	logic        refused_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [31:0] rd_data;
	logic [7:0]  page_reg;
	logic [15:0] offset_reg;
	logic [5:0]  latch_idx_reg;
	logic [5:0]  prog_idx_reg;
	logic [31:0] timer_reg;
	logic [23:0] row_base_reg;
	logic        mode_meta_reg;
	logic        mode_sync_reg;
	logic [23:0] latch_mem [ROW_WORDS];

	logic        bus_hit;
	logic        bus_wr;
	logic        ctrl_wr;
	logic        key_wr;
	logic        start_req;
	logic        start_ok;
	logic        is_row;
	logic        is_block;
	logic        is_bulk;
	logic [23:0] target_addr;

	function automatic logic [23:0] align_down(input logic [23:0] a, input int unsigned words);
		align_down = a & ~(24'(words) - 24'h000001);
	endfunction : align_down

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign bus_hit     = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign bus_wr      = bus_hit & wb_we_i;
	assign ctrl_wr     = bus_wr && (wb_adr_i == CTRL_OFS);
	assign key_wr      = bus_wr && (wb_adr_i == KEY_OFS) && wb_sel_i[0];
	assign target_addr = {page_reg, offset_reg};

	// Bits 13..7 and 5..4 have no storage, so writes to them vanish.
	always_comb begin
		cfg_next = cfg_reg;
		if (wb_sel_i[0]) begin
			cfg_next.erase = wb_dat_i[ERASE_BIT];
			cfg_next.op    = wb_dat_i[3:0];
		end
		if (wb_sel_i[1]) begin
			cfg_next.write_permit_bit = wb_dat_i[WRITE_PERMIT_BIT_BIT];
		end
	end

	// The start write checks the configuration it carries itself.
	assign is_block  = (cfg_next.op == OP_BLOCK_ERASE) && cfg_next.erase;
	assign is_row    = (cfg_next.op == OP_ROW_PROG) && !cfg_next.erase;
	assign is_bulk   = (cfg_next.op == OP_BULK_ERASE) && cfg_next.erase
	                   && mode_sync_reg;
	assign start_req = ctrl_wr && wb_sel_i[1] && wb_dat_i[START_BIT]
	                   && (state_reg == ST_IDLE);
	assign start_ok  = start_req && (key_reg == KEY_OPEN) && cfg_next.write_permit_bit
	                   && (is_block || is_row || is_bulk);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_meta_reg <= 1'b0;
			mode_sync_reg <= 1'b0;
		end else begin
			mode_meta_reg <= serial_prog_mode;
			mode_sync_reg <= mode_meta_reg;
		end
	end

	// ----------------------------------------
	// Unlock sequence
	// ----------------------------------------
	// Any other write breaks the sequence, so the unlock must be the
	// last thing software does before the start write consumes it.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			key_reg <= KEY_NONE;
		end else if (key_wr) begin
			if (wb_dat_i[7:0] == KEY_FIRST) begin
				key_reg <= KEY_HALF;
			end else if (wb_dat_i[7:0] == KEY_SECOND && key_reg == KEY_HALF) begin
				key_reg <= KEY_OPEN;
			end else begin
				key_reg <= KEY_NONE;
			end
		end else if (bus_wr) begin
			key_reg <= KEY_NONE;
		end
	end

	// ----------------------------------------
	// Configuration and address registers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_reg    <= flash_cfg_t'({CTRL_RESET[WRITE_PERMIT_BIT_BIT], CTRL_RESET[ERASE_BIT], CTRL_RESET[3:0]});
			page_reg   <= PAGE_RESET;
			offset_reg <= OFFSET_RESET;
		end else if (bus_wr && state_reg == ST_IDLE) begin
			if (wb_adr_i == CTRL_OFS) begin
				cfg_reg <= cfg_next;
			end
			if (wb_adr_i == PAGE_OFS && wb_sel_i[0]) begin
				page_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == OFFSET_OFS) begin
				if (wb_sel_i[0]) begin
					offset_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					offset_reg[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// ----------------------------------------
	// Latch buffers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latch_idx_reg <= 6'h00;
		end else if (bus_wr && state_reg == ST_IDLE) begin
			if (wb_adr_i == LATCH_IDX_OFS && wb_sel_i[0]) begin
				latch_idx_reg <= wb_dat_i[5:0];
			end else if (wb_adr_i == LATCH_DATA_OFS) begin
				latch_idx_reg <= latch_idx_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (bus_wr && state_reg == ST_IDLE && wb_adr_i == LATCH_DATA_OFS) begin
			latch_mem[latch_idx_reg] <= wb_dat_i[23:0];
		end
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	// The stall is raised at the start write so the processor cannot
	// run ahead of the array; the two no-ops only cover pipeline fill.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg    <= ST_IDLE;
			start_reg    <= 1'b0;
			stall_reg    <= 1'b0;
			refused_reg  <= 1'b0;
			timer_reg    <= 32'h0000_0000;
			prog_idx_reg <= 6'h00;
			row_base_reg <= 24'h000000;
			cmd_reg      <= '0;
		end else begin
			cmd_reg.wr_en <= 1'b0;
			cmd_reg.erase <= 1'b0;
			cmd_reg.bulk  <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start_req) begin
						refused_reg <= ~start_ok;
					end
					if (start_ok && is_row) begin
						start_reg    <= 1'b1;
						stall_reg    <= 1'b1;
						prog_idx_reg <= 6'h00;
						row_base_reg <= align_down(target_addr, ROW_WORDS);
						state_reg    <= ST_PROG_LOAD;
					end else if (start_ok) begin
						start_reg     <= 1'b1;
						stall_reg     <= 1'b1;
						cmd_reg.erase <= 1'b1;
						cmd_reg.bulk  <= is_bulk;
						cmd_reg.addr  <= align_down(target_addr, BLOCK_WORDS);
						timer_reg     <= ERASE_CYC - 32'd1;
						state_reg     <= ST_ERASE;
					end
				end
				ST_ERASE: begin
					if (timer_reg == 32'h0000_0000) begin
						start_reg <= 1'b0;
						stall_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						timer_reg <= timer_reg - 32'd1;
					end
				end
				ST_PROG_LOAD: begin
					cmd_reg.wr_en <= 1'b1;
					cmd_reg.addr  <= row_base_reg | {18'h00000, prog_idx_reg};
					cmd_reg.data  <= latch_mem[prog_idx_reg];
					prog_idx_reg  <= prog_idx_reg + 6'h01;
					if (prog_idx_reg == 6'(ROW_WORDS - 1)) begin
						timer_reg <= PROG_CYC - 32'd1;
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (timer_reg == 32'h0000_0000) begin
						start_reg <= 1'b0;
						stall_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						timer_reg <= timer_reg - 32'd1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read-back and bus answer
	// ----------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			CTRL_OFS: begin
				rd_data[START_BIT] = start_reg;
				rd_data[WRITE_PERMIT_BIT_BIT]  = cfg_reg.write_permit_bit;
				rd_data[ERASE_BIT] = cfg_reg.erase;
				rd_data[3:0]       = cfg_reg.op;
			end
			PAGE_OFS:      rd_data[7:0]  = page_reg;
			OFFSET_OFS:    rd_data[15:0] = offset_reg;
			STATUS_OFS:    rd_data[3:0]  = {mode_sync_reg, key_reg == KEY_OPEN, refused_reg, stall_reg};
			LATCH_IDX_OFS: rd_data[5:0]  = latch_idx_reg;
			default:       rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_hit;
			if (bus_hit && !wb_we_i) begin
				dat_reg <= rd_data;
			end
		end
	end

	assign wb_ack_o  = ack_reg;
	assign wb_dat_o  = dat_reg;
	assign cpu_stall = stall_reg;
	assign flash_cmd = cmd_reg;

endmodule : flash_program_erase_control

// ---- verif/flash_program_erase_control_monitor.sv ----
module flash_program_erase_control_monitor
	import flash_ctrl_pkg::*;
#(
	parameter int unsigned ERASE_CYC = 20,
	parameter int unsigned PROG_CYC  = 10
) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       cpu_stall,
	input wire flash_cmd_t flash_cmd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Row burst length
	// ----------------------------------------
	logic [6:0] run_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) run_reg <= 7'h00;
		else if (flash_cmd.wr_en) run_reg <= run_reg + 7'h01;
		else run_reg <= 7'h00;
	end

	// ----------------------------------------
	// Stall length
	// ----------------------------------------
	// The counter restarts whenever the stall drops, so each operation is measured on its own.
	logic [31:0] stall_cnt_reg;
	logic        was_erase_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stall_cnt_reg <= 32'h0000_0000;
			was_erase_reg <= 1'b0;
		end else begin
			if (cpu_stall) begin
				stall_cnt_reg <= stall_cnt_reg + 32'd1;
			end else begin
				stall_cnt_reg <= 32'h0000_0000;
			end
			if (flash_cmd.erase) begin
				was_erase_reg <= 1'b1;
			end else if (flash_cmd.wr_en) begin
				was_erase_reg <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	stall_cause_a: assert property ($rose(cpu_stall) |-> ##[0:1] (flash_cmd.erase || flash_cmd.wr_en))
		else $error("stall without flash operation");
	stall_len_a: assert property ($fell(cpu_stall)
		|-> stall_cnt_reg == (was_erase_reg ? ERASE_CYC : PROG_CYC + 32'd64))
		else $error("stall length differs from operation time");
	cmd_stall_a: assert property (flash_cmd.erase || flash_cmd.wr_en |-> cpu_stall)
		else $error("flash command outside stall");
	burst_len_a: assert property ($fell(flash_cmd.wr_en) |-> run_reg == 7'h40)
		else $error("row burst not 64 words");
	word_step_a: assert property (flash_cmd.wr_en && $past(flash_cmd.wr_en)
		|-> flash_cmd.addr == $past(flash_cmd.addr) + 24'h000001)
		else $error("row word address not consecutive");
	row_base_a: assert property ($rose(flash_cmd.wr_en) |-> flash_cmd.addr[5:0] == 6'h00)
		else $error("row burst not at row base");
	erase_align_a: assert property (flash_cmd.erase |-> flash_cmd.addr[8:0] == 9'h000)
		else $error("erase address not block aligned");
	erase_once_a: assert property (flash_cmd.erase |=> !flash_cmd.erase [*2])
		else $error("erase pulse repeated");

	cover property (flash_cmd.erase && !flash_cmd.bulk);
	cover property (flash_cmd.erase && flash_cmd.bulk);
	cover property ($fell(flash_cmd.wr_en));
endmodule : flash_program_erase_control_monitor

bind flash_program_erase_control flash_program_erase_control_monitor #(
	.ERASE_CYC(ERASE_CYC),
	.PROG_CYC (PROG_CYC)
) u_mon (
	.mclk     (mclk),
	.rst      (rst),
	.wb_cyc_i (wb_cyc_i),
	.wb_stb_i (wb_stb_i),
	.wb_ack_o (wb_ack_o),
	.cpu_stall(cpu_stall),
	.flash_cmd(flash_cmd)
);

// ---- verif/cpu_bus_model.sv ----
module cpu_bus_model
	import flash_ctrl_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        ack,
	input  wire logic [31:0] rdat,
	input  wire logic        stall,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      wdat
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
	end

	// Released address and data are inverted so a stale value never looks valid.
	task xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		{cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, s, d};
		do @(posedge mclk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb, we, adr, wdat} <= {3'b000, ~a, ~d};
	endtask : xfer

	task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, s, d, q);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 4'hf, 32'h00000000, q);
	endtask : rd

	task unlock;
		wr(KEY_OFS, 4'h1, 32'h00000055);
		wr(KEY_OFS, 4'h1, 32'h000000aa);
	endtask : unlock

	task start(input logic [15:0] c);
		wr(CTRL_OFS, 4'h3, {16'h0000, c});
		repeat (2) @(posedge mclk);
	endtask : start

	task wait_idle(output logic ok);
		int n;
		ok = 1'b0;
		for (n = 0; n < 1000; n++) begin
			@(posedge mclk);
			if (stall === 1'b0) begin
				ok = 1'b1;
				break;
			end
		end
	endtask : wait_idle
endmodule : cpu_bus_model

// ---- verif/flash_program_erase_control_test.sv ----
module flash_program_erase_control_test
	import flash_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk = 1'b0;
	logic        rst  = 1'b1;
	logic        smode = 1'b0;
	logic        cyc, stb, we, ack, stall, ok;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [23:0] er_addr;
	logic        er_bulk;
	flash_cmd_t  cmd;
	int          error_cnt, cmp_count, wr_n, er_n, base_n;
	logic [15:0] cfg [5] = '{16'hc042, 16'h8042, 16'hc043, 16'hc002, 16'hc041};
	int          key [5] = '{0, 1, 1, 1, 2};

	always #2 mclk = ~mclk;

	flash_program_erase_control #(.ERASE_CYC(20), .PROG_CYC(10)) u_dut (
		.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.serial_prog_mode(smode), .cpu_stall(stall), .flash_cmd(cmd));

	cpu_bus_model u_cpu (
		.mclk(mclk), .ack(ack), .rdat(rdat), .stall(stall), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .wdat(wdat));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task complete_run;
		$display("Mismatches %0d in %0d checks", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// Both rows land back to back from one base, so the word count gives address and data.
	always @(posedge mclk) begin
		if (cmd.wr_en === 1'b1) begin
			chk("row_addr", 32'h00010200 + 32'(wr_n), {8'h00, cmd.addr});
			chk("row_data", 32'h005a0200 + 32'(wr_n), {8'h00, cmd.data});
			wr_n++;
		end
		if (cmd.erase === 1'b1) begin
			er_n++;
			er_addr = cmd.addr;
			er_bulk = cmd.bulk;
		end
	end

	task go(input logic [15:0] c);
		u_cpu.unlock();
		u_cpu.start(c);
		u_cpu.rd(CTRL_OFS, q);
		chk("busy_bit", 32'h8000, q & 32'h8000);
		u_cpu.rd(STATUS_OFS, q);
		chk("busy_status", 32'h1, q & 32'h3);
		u_cpu.wait_idle(ok);
		chk("op_done", 32'h1, {31'h0, ok});
		u_cpu.rd(CTRL_OFS, q);
		chk("start_clear", 32'h0, q & 32'h8000);
	endtask : go

	initial begin
		#40000;
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		u_cpu.rd(CTRL_OFS, q);
		chk("ctrl_reset", 32'h0, q);
		u_cpu.wr(CTRL_OFS, 4'h3, 32'h00007fff);
		u_cpu.rd(CTRL_OFS, q);
		chk("ctrl_bits", 32'h404f, q);
		u_cpu.rd(8'h40, q);
		chk("unmapped", 32'h0, q);
		for (int i = 0; i < 5; i++) begin
			base_n = er_n + wr_n;
			if (key[i] == 1) u_cpu.unlock();
			if (key[i] == 2) begin
				u_cpu.wr(KEY_OFS, 4'h1, 32'h000000aa);
				u_cpu.wr(KEY_OFS, 4'h1, 32'h00000055);
			end
			u_cpu.start(cfg[i]);
			u_cpu.rd(CTRL_OFS, q);
			chk("refused_start", 32'h0, q & 32'h8000);
			u_cpu.rd(STATUS_OFS, q);
			chk("refused_flag", 32'h2, q & 32'h2);
			chk("no_command", base_n, er_n + wr_n);
		end
		u_cpu.wr(PAGE_OFS, 4'h1, 32'h00000001);
		u_cpu.wr(OFFSET_OFS, 4'h3, 32'h00000234);
		go(16'hc042);
		chk("erase_count", 32'd1, er_n);
		chk("erase_base", 32'h010200, {8'h00, er_addr});
		for (int r = 0; r < 2; r++) begin
			u_cpu.wr(OFFSET_OFS, 4'h3, 32'h00000200 + 32'(64 * r));
			u_cpu.wr(LATCH_IDX_OFS, 4'h1, 32'h00000000);
			for (int i = 0; i < 64; i++) begin
				u_cpu.wr(LATCH_DATA_OFS, 4'hf, 32'h005a0200 + 32'(64 * r + i));
			end
			u_cpu.rd(LATCH_IDX_OFS, q);
			chk("latch_wrap", 32'h0, q);
			go(16'hc001);
			chk("row_words", 32'(64 * (r + 1)), wr_n);
		end
		smode <= 1'b1;
		repeat (4) @(posedge mclk);
		u_cpu.rd(STATUS_OFS, q);
		chk("serial_mode", 32'h8, q & 32'h8);
		go(16'hc043);
		chk("bulk_erase", 32'h1, {31'h0, er_bulk});
		chk("erase_total", 32'd2, er_n);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		u_cpu.rd(PAGE_OFS, q);
		chk("page_reset", 32'h0, q);
		u_cpu.rd(CTRL_OFS, q);
		chk("ctrl_reset2", 32'h0, q);
		complete_run();
	end
endmodule : flash_program_erase_control_test
